/* shared/rtc_pkg.sv */
package rtc_pkg;
  // ==========================================================================
  // sizes
  localparam int unsigned DEPTH      = 2047;
  localparam int unsigned PTR_W      = 11;
  localparam int unsigned ENTRY_W    = 32;
  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_RANGE   = 8'h04;
  localparam logic [7:0] OFS_START   = 8'h08;
  localparam logic [7:0] OFS_STOP1   = 8'h0C;
  localparam logic [7:0] OFS_STOP2   = 8'h10;
  localparam logic [7:0] OFS_STATUS  = 8'h14;
  localparam logic [7:0] OFS_COUNT   = 8'h18;
  localparam logic [7:0] OFS_PTR     = 8'h1C;
  localparam logic [7:0] OFS_IRQST   = 8'h20;
  localparam logic [7:0] OFS_IRQMSK  = 8'h24;
  localparam logic [7:0] OFS_RDIDX   = 8'h28;
  localparam logic [7:0] OFS_RDDATA  = 8'h2C;
  // ==========================================================================
  // control field positions (CTRL)
  localparam int unsigned CTRL_MODE_LO = 0;
  localparam int unsigned CTRL_GO      = 4;
  localparam int unsigned CTRL_USE_BEG = 5;
  localparam int unsigned CTRL_USE_S1  = 6;
  localparam int unsigned CTRL_USE_S2  = 7;
  localparam int unsigned CTRL_MONBRK  = 8;
  // interrupt bits
  localparam int unsigned IRQ_DONE     = 0;
  localparam int unsigned IRQ_BREAK    = 1;
  localparam int unsigned IRQ_EVENT    = 2;
  // reset values
  localparam logic [10:0] RANGE_RST    = 11'h7FF;
  localparam logic [2:0]  MODE_RST     = 3'h0;
  // ==========================================================================
  typedef enum logic [2:0] {
    fill_from_run_start,
    keep_last_until_break,
    fill_after_trigger,
    surround_trigger,
    stop_on_trigger_keep_last,
    repeated_trigger_snapshots
  } rtc_mode_t;
endpackage : rtc_pkg

/* rtl/rtc_buffer.sv */
module rtc_buffer (
  input  wire logic                       hclk,
  input  wire logic                       we,
  input  wire logic [rtc_pkg::PTR_W-1:0]  waddr,
  input  wire logic [rtc_pkg::ENTRY_W-1:0] wdata,
  input  wire logic [rtc_pkg::PTR_W-1:0]  raddr,
  output logic      [rtc_pkg::ENTRY_W-1:0] rdata
);
  import rtc_pkg::*;
  // ==========================================================================
  // storage, flip-flops indexed by pointer; no reset on the data
  logic [ENTRY_W-1:0] mem_q [DEPTH];
  always_ff @(posedge hclk) begin
    if (we && (waddr < PTR_W'(DEPTH))) begin
      mem_q[waddr] <= wdata;
    end
    rdata <= (raddr < PTR_W'(DEPTH)) ? mem_q[raddr] : '0;
  end
endmodule : rtc_buffer

/* rtl/rtc_capture.sv */
// Operation
// - each entry is 32 bits: status, address high/low, data
// - buffer holds 2047 entries; range limits storage except two end modes
// - every executed cycle is stored while recording
// - wrapping modes overwrite the oldest entry once full
// - six trigger modes chosen by the mode field
// - fill_from_run_start: run starts, stop without wrap at range
// - keep_last_until_break: run starts, wrap, stop on break, range ignored
// - fill_after_trigger: event starts, stop without wrap after range entries
// - surround_trigger: run starts, wrap, stop range cycles after event
// - stop_on_trigger_keep_last: run starts, wrap, stop at event, range ignored
// - repeated_trigger_snapshots: range per event, pause, stop when buffer full
// - run starts at given address, else at current program counter
// - with no stop address run continues until breakpoint or monitor break
// - two stop addresses break at whichever is reached first
// - fill_after_trigger does not store the event cycle itself
// - surround_trigger keeps the event cycle among pre-event entries
//
// Implementation choices: the register offsets and register access over AHB-Lite.
module rtc_capture (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        cyc_done,
  input  wire logic [15:0] cyc_addr,
  input  wire logic [7:0]  cyc_data,
  input  wire logic [7:0]  cyc_status,
  input  wire logic        event_match,
  input  wire logic        breakpoint_hit,
  output logic             target_run,
  output logic             load_pc,
  output logic      [15:0] load_pc_addr,
  output logic             irq
);
  import rtc_pkg::*;
  // ==========================================================================
  // pin synchronisers
  logic [1:0]  s1_q, s2_q;
  logic [31:0] cyc_s1_q, cyc_s2_q;
  logic        done_d1_q;
  logic        done_s1_q, done_s2_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q      <= '0;
      s2_q      <= '0;
      cyc_s1_q  <= '0;
      cyc_s2_q  <= '0;
      done_d1_q <= 1'b0;
    end else begin
      s1_q      <= {event_match, breakpoint_hit};
      s2_q      <= s1_q;
      cyc_s1_q  <= {cyc_status, cyc_addr, cyc_data};
      cyc_s2_q  <= cyc_s1_q;
      done_d1_q <= done_s2_q;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
    end else begin
      done_s1_q <= cyc_done;
      done_s2_q <= done_s1_q;
    end
  end
  logic cyc_stb, ev, bp;
  assign cyc_stb = done_s2_q & ~done_d1_q;
  assign ev      = s2_q[1] & cyc_stb;
  assign bp      = s2_q[0];
  // ==========================================================================
  // bus slave
  logic        ph_wr_q, ph_rd_q;
  logic [7:0]  ph_a_q;
  logic [8:0]  ctrl_q, ctrl_d;
  logic [10:0] range_q, range_d;
  logic [15:0] beg_q, beg_d, stop1_q, stop1_d, stop2_q, stop2_d;
  logic [2:0]  ist_q, ist_d, imsk_q, imsk_d;
  logic [10:0] rdidx_q, rdidx_d;
  logic        go_pulse;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr_q <= 1'b0;
      ph_rd_q <= 1'b0;
      ph_a_q  <= '0;
    end else if (hready) begin
      ph_wr_q <= hsel & htrans[1] & hwrite;
      ph_rd_q <= hsel & htrans[1] & ~hwrite;
      ph_a_q  <= haddr[7:0];
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  function automatic logic hit(input logic [7:0] ofs);
    hit = ph_wr_q && (ph_a_q == ofs);
  endfunction : hit
  assign go_pulse = hit(OFS_CTRL) && hwdata[CTRL_GO];
  // ==========================================================================
  // capture engine
  typedef enum logic [1:0] {st_idle, st_arm, st_rec, st_pause} rtc_state_t;
  rtc_state_t  st_q, st_d;
  rtc_mode_t   mode;
  rtc_mode_t   go_mode;
  logic [10:0] wp_q, wp_d, cnt_q, cnt_d, seg_q, seg_d;
  logic        full_q, full_d, evseen_q, evseen_d, run_q, run_d, brk;
  logic        done_ev, brk_ev, ev_ev, store;
  logic [10:0] lim;
  assign mode = rtc_mode_t'(ctrl_q[CTRL_MODE_LO +: 3]);
  // the run command and its mode arrive in the same write
  assign go_mode = rtc_mode_t'(hwdata[CTRL_MODE_LO +: 3]);
  assign lim  = (range_q == 11'h000 || range_q > 11'h7FF) ? 11'h7FF : range_q;
  assign brk = run_q & cyc_stb & (bp | ctrl_q[CTRL_MONBRK]
             | (ctrl_q[CTRL_USE_S1] & cyc_s2_q[23:8] == stop1_q)
             | (ctrl_q[CTRL_USE_S2] & cyc_s2_q[23:8] == stop2_q));
  always_comb begin
    st_d     = st_q;
    wp_d     = wp_q;
    cnt_d    = cnt_q;
    seg_d    = seg_q;
    full_d   = full_q;
    evseen_d = evseen_q;
    run_d    = run_q;
    store    = 1'b0;
    done_ev  = 1'b0;
    ev_ev    = 1'b0;
    brk_ev   = brk;
    if (brk) begin
      run_d = 1'b0;
    end
    if (go_pulse) begin
      run_d    = 1'b1;
      wp_d     = '0;
      cnt_d    = '0;
      seg_d    = '0;
      full_d   = 1'b0;
      evseen_d = 1'b0;
      st_d     = (go_mode == fill_after_trigger || go_mode == repeated_trigger_snapshots)
                 ? st_arm : st_rec;
    end else if (cyc_stb && run_q) begin
      case (st_q)
        st_arm, st_pause: begin
          if (ev) begin
            st_d  = st_rec;
            seg_d = '0;
            ev_ev = 1'b1;
          end
        end
        st_rec: begin
          store = 1'b1;
          wp_d  = (wp_q == 11'(DEPTH - 1)) ? '0 : wp_q + 11'h001;
          if (!full_q) begin
            cnt_d = cnt_q + 11'h001;
          end
          if (wp_q == 11'(DEPTH - 1)) begin
            full_d = 1'b1;
          end
          seg_d = seg_q + 11'h001;
          case (mode)
            fill_from_run_start, fill_after_trigger: begin
              if (seg_q + 11'h001 >= lim) begin
                st_d    = st_idle;
                done_ev = 1'b1;
              end
            end
            keep_last_until_break: begin
              if (brk) begin
                st_d    = st_idle;
                done_ev = 1'b1;
              end
            end
            surround_trigger: begin
              if (ev && !evseen_q) begin
                evseen_d = 1'b1;
                seg_d    = '0;
                ev_ev    = 1'b1;
              end else if (evseen_q && seg_q + 11'h001 >= lim) begin
                st_d    = st_idle;
                done_ev = 1'b1;
              end
            end
            stop_on_trigger_keep_last: begin
              if (ev) begin
                st_d    = st_idle;
                done_ev = 1'b1;
                ev_ev   = 1'b1;
              end
            end
            repeated_trigger_snapshots: begin
              wp_d = wp_q + 11'h001;
              if (cnt_q + 11'h001 >= 11'(DEPTH)) begin
                st_d    = st_idle;
                done_ev = 1'b1;
              end else if (seg_q + 11'h001 >= lim) begin
                st_d = st_pause;
              end
            end
            default: st_d = st_idle;
          endcase
        end
        default: st_d = st_idle;
      endcase
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q     <= st_idle;
      wp_q     <= '0;
      cnt_q    <= '0;
      seg_q    <= '0;
      full_q   <= 1'b0;
      evseen_q <= 1'b0;
      run_q    <= 1'b0;
    end else begin
      st_q     <= st_d;
      wp_q     <= wp_d;
      cnt_q    <= cnt_d;
      seg_q    <= seg_d;
      full_q   <= full_d;
      evseen_q <= evseen_d;
      run_q    <= run_d;
    end
  end
  // ==========================================================================
  // registers
  always_comb begin
    ctrl_d  = ctrl_q;
    range_d = range_q;
    beg_d   = beg_q;
    stop1_d = stop1_q;
    stop2_d = stop2_q;
    imsk_d  = imsk_q;
    rdidx_d = rdidx_q;
    ist_d   = ist_q;
    ctrl_d[CTRL_GO]     = 1'b0;
    // monitor break stays pending until a cycle strobe of a run takes it
    ctrl_d[CTRL_MONBRK] = ctrl_q[CTRL_MONBRK] & ~(cyc_stb & run_q);
    if (hit(OFS_CTRL))   ctrl_d  = hwdata[8:0];
    if (hit(OFS_RANGE))  range_d = hwdata[10:0];
    if (hit(OFS_START))  beg_d   = hwdata[15:0];
    if (hit(OFS_STOP1))  stop1_d = hwdata[15:0];
    if (hit(OFS_STOP2))  stop2_d = hwdata[15:0];
    if (hit(OFS_IRQMSK)) imsk_d  = hwdata[2:0];
    if (hit(OFS_RDIDX))  rdidx_d = hwdata[10:0];
    if (hit(OFS_IRQST))  ist_d   = ist_q & ~hwdata[2:0];
    ist_d = ist_d | {ev_ev, brk_ev, done_ev};
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q  <= {6'h00, MODE_RST};
      range_q <= RANGE_RST;
      beg_q   <= '0;
      stop1_q <= '0;
      stop2_q <= '0;
      imsk_q  <= '0;
      rdidx_q <= '0;
      ist_q   <= '0;
    end else begin
      ctrl_q  <= ctrl_d;
      range_q <= range_d;
      beg_q   <= beg_d;
      stop1_q <= stop1_d;
      stop2_q <= stop2_d;
      imsk_q  <= imsk_d;
      rdidx_q <= rdidx_d;
      ist_q   <= ist_d;
    end
  end
  // ==========================================================================
  // outputs and read mux
  logic [31:0] buf_rd;
  logic [31:0] rd_d;
  rtc_buffer u_buf (
    .hclk  (hclk),
    .we    (store),
    .waddr (wp_q),
    .wdata (cyc_s2_q),
    .raddr (rdidx_d),
    .rdata (buf_rd)
  );
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      load_pc      <= 1'b0;
      load_pc_addr <= '0;
      irq          <= 1'b0;
    end else begin
      load_pc      <= go_pulse & hwdata[CTRL_USE_BEG];
      load_pc_addr <= hit(OFS_START) ? hwdata[15:0] : beg_q;
      irq          <= |(ist_d & imsk_d);
    end
  end
  assign target_run = run_q;
  always_comb begin
    case (ph_a_q)
      OFS_CTRL:   rd_d = {23'h0, ctrl_q};
      OFS_RANGE:  rd_d = {21'h0, range_q};
      OFS_START:  rd_d = {16'h0, beg_q};
      OFS_STOP1:  rd_d = {16'h0, stop1_q};
      OFS_STOP2:  rd_d = {16'h0, stop2_q};
      OFS_STATUS: rd_d = {26'h0, full_q, evseen_q, run_q, 1'b0, st_q};
      OFS_COUNT:  rd_d = {21'h0, cnt_q};
      OFS_PTR:    rd_d = {21'h0, wp_q};
      OFS_IRQST:  rd_d = {29'h0, ist_q};
      OFS_IRQMSK: rd_d = {29'h0, imsk_q};
      OFS_RDIDX:  rd_d = {21'h0, rdidx_q};
      OFS_RDDATA: rd_d = buf_rd;
      default:    rd_d = 32'h0000_0000;
    endcase
  end
  assign hrdata = ph_rd_q ? rd_d : 32'h0000_0000;
endmodule : rtc_capture

/* bench/rtc_capture_properties.sv */
module rtc_capture_properties (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        cyc_done,
  input wire logic        breakpoint_hit,
  input wire logic        target_run,
  input wire logic        load_pc
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // data phase trackers
  logic wph_q;
  logic rph_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wph_q <= 1'b0;
      rph_q <= 1'b0;
    end else begin
      wph_q <= hsel & htrans[1] & hready & hwrite;
      rph_q <= hsel & htrans[1] & hready & ~hwrite;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========================================================================
  // properties
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("error response seen");
  property p_ready; hreadyout == 1'b1; endproperty
  a_ready: assert property (p_ready) else $error("wait state inserted");
  property p_rd_idle; !rph_q |-> hrdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside data phase");
  property p_pc_pulse; load_pc |=> !load_pc; endproperty
  a_pc_pulse: assert property (p_pc_pulse) else $error("pc load longer than one cycle");
  property p_pc_cause; $rose(load_pc) |-> $past(wph_q) || $past(wph_q, 2); endproperty
  a_pc_cause: assert property (p_pc_cause) else $error("pc load without write");
  property p_run_cause; $rose(target_run) |-> $past(wph_q) || $past(wph_q, 2); endproperty
  a_run_cause: assert property (p_run_cause) else $error("run without write");
  property p_pc_run; load_pc |-> ##[0:2] target_run; endproperty
  a_pc_run: assert property (p_pc_run) else $error("pc load without run");
  property p_brk; $rose(cyc_done) && breakpoint_hit && target_run |-> ##[1:8] !target_run;
  endproperty
  a_brk: assert property (p_brk) else $error("breakpoint did not stop run");
endmodule : rtc_capture_properties

bind rtc_capture rtc_capture_properties rtc_capture_properties_inst (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cyc_done(cyc_done),
  .breakpoint_hit(breakpoint_hit), .target_run(target_run), .load_pc(load_pc));

/* bench/rtc_target_model.sv */
module rtc_target_model (
  input  wire logic        hclk,
  output logic             cyc_done,
  output logic      [15:0] cyc_addr,
  output logic      [7:0]  cyc_data,
  output logic      [7:0]  cyc_status,
  output logic             event_match,
  output logic             breakpoint_hit
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {cyc_done, event_match, breakpoint_hit} = 3'h0;
    {cyc_status, cyc_addr, cyc_data} = 32'h0;
  end
  // one machine cycle: bus settles first, strobe high 4, released bus inverted
  task cycle(input logic [31:0] w, input logic ev, input logic bp);
    @(posedge hclk);
    {cyc_status, cyc_addr, cyc_data} <= w;
    event_match <= ev;
    breakpoint_hit <= bp;
    @(posedge hclk);
    cyc_done <= 1'b1;
    repeat (4) @(posedge hclk);
    cyc_done <= 1'b0;
    @(posedge hclk);
    {cyc_status, cyc_addr, cyc_data} <= ~w;
    {event_match, breakpoint_hit} <= 2'h0;
    repeat (3) @(posedge hclk);
  endtask : cycle
endmodule : rtc_target_model

/* bench/rtc_capture_tb_top.sv */
module rtc_capture_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rtc_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, irq;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rv;
  logic [1:0] htrans = 0;
  logic [15:0] cyc_addr, load_pc_addr, pca;
  logic [7:0] cyc_data, cyc_status;
  logic cyc_done, event_match, breakpoint_hit, target_run, load_pc;
  int err_count = 0, n_checks = 0, tick = 0, pcs = 0;
  logic [31:0] q[$];
  int mmode, mrng, mon, mdone, mev, mpost, mcnt, mwr;
  always #10 hclk = ~hclk;
  rtc_capture rtc_capture_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .cyc_done,
    .cyc_addr, .cyc_data, .cyc_status, .event_match, .breakpoint_hit, .target_run,
    .load_pc, .load_pc_addr, .irq);
  rtc_target_model rtc_target_model_inst (.hclk, .cyc_done, .cyc_addr, .cyc_data,
    .cyc_status, .event_match, .breakpoint_hit);
  always @(posedge hclk) begin
    tick++;
    if (load_pc === 1'b1) begin
      pcs++;
      pca = load_pc_addr;
    end
    if (tick == 60000) begin
      err_count++;
      test_done();
    end
  end
  task test_done;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 24'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rv = hrdata;
  endtask : xfer
  task put(input logic [31:0] w);
    q.push_back(w);
    mwr++;
    if (q.size() > DEPTH) void'(q.pop_front());
  endtask : put
  // drive the cycle into the design, then step the reference capture model with it
  task cyc(input logic [31:0] w, input logic ev, input logic bp);
    rtc_target_model_inst.cycle(w, ev, bp);
    if (!mdone) case (mmode)
      0, 2: if (mon) begin
        put(w);
        if (q.size() == mrng) mdone = 1;
      end else if (ev) mon = 1;
      1, 4: begin
        put(w);
        if (mmode == 4 && ev) mdone = 1;
      end
      3: begin
        put(w);
        if (mev) begin
          mpost++;
          if (mpost == mrng) mdone = 1;
        end else if (ev) mev = 1;
      end
      default: if (mon) begin
        put(w);
        mcnt++;
        if (mcnt == mrng) mon = 0;
        if (q.size() == DEPTH) mdone = 1;
      end else if (ev) {mon, mcnt} = {32'h1, 32'h0};
    endcase
  endtask : cyc
  task trace(input int md, input int rg, input int n, input logic [31:0] evs);
    xfer(OFS_RANGE, 1, rg);
    xfer(OFS_CTRL, 1, 32'h10 | md);
    {mmode, mrng, mdone, mev, mpost, mwr} = {md, rg, 128'h0};
    mon = (md != 2 && md != 5);
    q = {};
    for (int i = 0; i < n; i++) cyc($urandom, i < 32 && evs[i], 0);
    xfer(OFS_COUNT, 0, 0);
    chk(rv, q.size());
    xfer(OFS_PTR, 0, 0);
    chk(rv, mwr % DEPTH);
    for (int i = q.size() > 6 ? q.size() - 3 : 0; i < q.size(); i++) begin
      xfer(OFS_RDIDX, 1, (mwr - q.size() + i) % DEPTH);
      xfer(OFS_RDDATA, 0, 0);
      chk(rv, q[i]);
    end
  endtask : trace
  initial begin
    void'($urandom(44));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(OFS_RANGE, 0, 0);
    chk(rv, RANGE_RST);
    trace(0, 3, 6, 0);
    xfer(OFS_IRQST, 0, 0);
    chk(rv, 32'h1);
    chk(irq, 0);
    xfer(OFS_IRQMSK, 1, 32'h1);
    xfer(8'h30, 0, 0);
    chk(rv, 0);
    chk(irq, 1);
    xfer(OFS_IRQST, 1, 32'h1);
    xfer(OFS_IRQST, 0, 0);
    chk(rv, 0);
    chk(irq, 0);
    trace(1, 5, 2050, 0);
    trace(2, 3, 8, 32'h4);
    trace(3, 2, 8, 32'h8);
    trace(4, 3, 8, 32'h10);
    trace(5, 2, 12, 32'h84);
    xfer(OFS_START, 1, 32'h1234);
    xfer(OFS_STOP1, 1, 32'hA0A0);
    xfer(OFS_STOP2, 1, 32'h5050);
    xfer(OFS_CTRL, 1, 32'hF0);
    repeat (2) @(posedge hclk);
    chk({pcs[15:0], pca}, {16'h0001, 16'h1234});
    cyc(32'h1122_3344, 0, 0);
    chk(target_run, 1);
    cyc(32'h0050_5000, 0, 0);
    chk(target_run, 0);
    xfer(OFS_CTRL, 1, 32'hD0);
    cyc(32'h00A0_A000, 0, 0);
    chk(target_run, 0);
    xfer(OFS_CTRL, 1, 32'h10);
    for (int i = 0; i < 4; i++) cyc($urandom, 0, 0);
    chk({pcs[30:0], target_run}, {31'h1, 1'b1});
    cyc($urandom, 0, 1);
    chk(target_run, 0);
    xfer(OFS_CTRL, 1, 32'h10);
    xfer(OFS_CTRL, 1, 32'h100);
    cyc($urandom, 0, 0);
    cyc($urandom, 0, 0);
    chk(target_run, 0);
    test_done();
  end
endmodule : rtc_capture_tb_top
